/* File: rtl/pwm_fault_params.svh */
// Register offsets, field positions, reset values and widths of the fault trip and capture block.
`ifndef PWM_FAULT_PARAMS_SVH
`define PWM_FAULT_PARAMS_SVH

`define ADDR_W 12
`define OFS_TRIP_ACTION_CFG 12'h0D8
`define OFS_TRIP_CONTROL 12'h0DC
`define OFS_TRIP_STATUS 12'h0E0
`define OFS_FAULT_INPUT_DETECT 12'h0E4
`define OFS_CAPTURE_TIMER_CFG 12'h0E8
`define OFS_CAPTURE_TIMER_PHASE 12'h0EC
`define OFS_CAPTURE_CHAN0_CFG 12'h0F0
`define OFS_CAPTURE_CHAN1_CFG 12'h0F4
`define OFS_CAPTURE_CHAN0_VALUE 12'h0FC
`define OFS_CAPTURE_CHAN1_VALUE 12'h100
`define OFS_CAPTURE_EDGE_STATUS 12'h108

// trip_action_cfg fields.
`define TA_SW_CBC 0
`define TA_F_CBC 1
`define TA_SW_OST 4
`define TA_F_OST 5
`define TA_A_CBC_D 8
`define TA_A_CBC_U 10
`define TA_A_OST_D 12
`define TA_A_OST_U 14
`define TA_B_CBC_D 16
`define TA_B_CBC_U 18
`define TA_B_OST_D 20
`define TA_B_OST_U 22
`define TA_W 24
`define TA_RESET 24'h000000

// trip_control fields.
`define TC_CLR_OST 0
`define TC_REFRESH 1
`define TC_FORCE_CBC 3
`define TC_FORCE_OST 4
`define TC_W 5
`define TC_RESET 5'h00

// trip_status fields.
`define TS_CBC_ON 0
`define TS_OST_ON 1

// fault_input_detect fields.
`define FD_GEN_EN 0
`define FD_POLE 3
`define FD_ACTIVE 6
`define FD_W 6
`define FD_RESET 6'h00

// capture_timer_cfg fields.
`define CT_RUN 0
`define CT_SYNC_EN 1
`define CT_SYNC_SEL 2
`define CT_SW_SYNC 5
`define CT_W 5
`define CT_RESET 5'h00
`define PHASE_RESET 32'h00000000

// capture_chanN_cfg fields.
`define CC_EN 0
`define CC_MODE 1
`define CC_PRESCALE 3
`define CC_INVERT 11
`define CC_SW 12
`define CC_W 12
`define CC_RESET 12'h000

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: rtl/pwm_fault_pkg.sv */
// Types shared by the fault trip and capture block.
package pwm_fault_pkg;
  typedef enum logic [1:0] {
    ACT_KEEP,
    ACT_LOW,
    ACT_HIGH,
    ACT_TOGGLE
  } trip_action_e;

  typedef logic [2:0] sync_sel_t;
endpackage

/* File: rtl/pwm_fault_trip_and_capture.sv */
// Fault trip handler for one operator pair plus capture timer and capture channels 0 and 1.
//
// Notes on behaviour
// - One-shot trip applies per-direction action to output_a and output_b: keep, low, high, toggle.
// - Cycle trip applies its own up and down actions with the same encoding.
// - Each fault event starts one-shot or cycle trip only when its enable is set.
// - Software-forced trips act only while their enable bits are set.
// - Any change of the force-one-shot bit starts a one-shot trip.
// - Any change of the force-cycle-trip bit starts a cycle trip.
// - Cycle trip ends or refreshes at zero event (bit0) and period event (bit1).
// - One-shot trip holds until the clear-one-shot bit changes value.
// - Two read-only flags show one-shot and cycle trip activity.
// - Each fault event has a read-only flag following the event.
// - Fault is a level; polarity 0 active low, 1 active high.
// - A fault event is generated only while its generation enable is set.
// - Writing 1 to software sync loads phase into the capture timer; write-only.
// - Sync source: 0 none, 1-3 timer syncs, 4-6 external syncs; needs sync enable.
// - Capture timer counts each clock while run is set, holds otherwise.
// - A 32-bit phase value is loaded on any sync.
// - Writing 1 to software capture captures immediately; write-only.
// - Invert bit inverts the capture input before the prescaler.
// - Prescaler passes one rising edge per prescale plus one rising edges.
// - Edge select bit0 captures falling, bit1 rising; both may be set.
// - A channel captures only while its enable is set.
// - Each capture stores the capture timer in the channel's value register.
// - Each channel records last capture edge: 0 rising, 1 falling.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "pwm_fault_params.svh"

module pwm_fault_trip_and_capture (
  input wire logic clk_sys_in, // System clock, 100 MHz.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic [`ADDR_W-1:0] s_axi_awaddr_in, // Write address.
  input wire logic s_axi_awvalid_in, // Write address valid.
  output logic s_axi_awready_out, // Write address ready.
  input wire logic [31:0] s_axi_wdata_in, // Write data.
  input wire logic [3:0] s_axi_wstrb_in, // Write byte strobes.
  input wire logic s_axi_wvalid_in, // Write data valid.
  output logic s_axi_wready_out, // Write data ready.
  output logic [1:0] s_axi_bresp_out, // Write response.
  output logic s_axi_bvalid_out, // Write response valid.
  input wire logic s_axi_bready_in, // Write response ready.
  input wire logic [`ADDR_W-1:0] s_axi_araddr_in, // Read address.
  input wire logic s_axi_arvalid_in, // Read address valid.
  output logic s_axi_arready_out, // Read address ready.
  output logic [31:0] s_axi_rdata_out, // Read data.
  output logic [1:0] s_axi_rresp_out, // Read response.
  output logic s_axi_rvalid_out, // Read data valid.
  input wire logic s_axi_rready_in, // Read data ready.
  input wire logic [2:0] fault_pin_in, // Fault pins 0 to 2, asynchronous.
  input wire logic [1:0] capture_input_in, // Capture pins 0 and 1, asynchronous.
  input wire logic [2:0] ext_sync_in, // External sync pins 0 to 2, asynchronous.
  input wire logic [2:0] timer_sync_in, // Sync pulses of PWM timers 0 to 2.
  input wire logic [15:0] timer_count_in, // Operator timer value.
  input wire logic [15:0] timer_period_in, // Operator timer period.
  input wire logic timer_dir_down_in, // Operator timer counts down when high.
  input wire logic gen_a_in, // Generator output for output_a.
  input wire logic gen_b_in, // Generator output for output_b.
  output logic output_a_out, // Tripped output_a.
  output logic output_b_out // Tripped output_b.
);
  // Bus write and read side.
  logic aw_got_q, w_got_q, bvalid_q, wr_fire;
  logic [`ADDR_W-1:0] waddr_q, raddr;
  logic [31:0] wdata_q, wmask, rdata_q, rd_mux;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic rvalid_q, rd_hit, wr_hit;

  // Registers.
  logic [`TA_W-1:0] trip_action_q;
  logic [`TC_W-1:0] trip_ctrl_q;
  logic [`FD_W-1:0] detect_cfg_q;
  logic [`CT_W-1:0] cap_tcfg_q;
  logic [31:0] phase_q, cap_timer_q;
  logic [2:0] fault_active_q;
  logic ost_q, cbc_q, out_a_q, out_b_q;

  // Synchronisers.
  logic [2:0] fault_s1_q, fault_s2_q, esync_s1_q, esync_s2_q, esync_prev_q;
  logic [1:0] cap_s1_q, cap_s2_q;

  assign s_axi_awready_out = !aw_got_q && !bvalid_q;
  assign s_axi_wready_out = !w_got_q && !bvalid_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign output_a_out = out_a_q;
  assign output_b_out = out_b_q;

  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // Write address and data are taken in either order; the write lands when both are held.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_q <= 1'b1;
        waddr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (waddr_q)
      `OFS_TRIP_ACTION_CFG, `OFS_TRIP_CONTROL, `OFS_FAULT_INPUT_DETECT,
      `OFS_CAPTURE_TIMER_CFG, `OFS_CAPTURE_TIMER_PHASE, `OFS_CAPTURE_CHAN0_CFG,
      `OFS_CAPTURE_CHAN1_CFG, `OFS_TRIP_STATUS, `OFS_CAPTURE_CHAN0_VALUE,
      `OFS_CAPTURE_CHAN1_VALUE, `OFS_CAPTURE_EDGE_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Toggle commands: a write that changes the stored bit is one trigger.
  logic ctrl_wr, force_ost_evt, force_cbc_evt, clear_ost_evt;
  assign ctrl_wr = wr_fire && waddr_q == `OFS_TRIP_CONTROL && wstrb_q[0];
  assign force_ost_evt = ctrl_wr &&
    (wdata_q[`TC_FORCE_OST] != trip_ctrl_q[`TC_FORCE_OST]);
  assign force_cbc_evt = ctrl_wr &&
    (wdata_q[`TC_FORCE_CBC] != trip_ctrl_q[`TC_FORCE_CBC]);
  assign clear_ost_evt = ctrl_wr &&
    (wdata_q[`TC_CLR_OST] != trip_ctrl_q[`TC_CLR_OST]);

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      trip_action_q <= `TA_RESET;
      trip_ctrl_q <= `TC_RESET;
      detect_cfg_q <= `FD_RESET;
      cap_tcfg_q <= `CT_RESET;
      phase_q <= `PHASE_RESET;
    end else if (wr_fire) begin
      unique case (waddr_q)
        `OFS_TRIP_ACTION_CFG: trip_action_q <=
          `TA_W'(merge({8'h00, trip_action_q}, wdata_q, wmask));
        `OFS_TRIP_CONTROL: trip_ctrl_q <=
          `TC_W'(merge({27'h0000000, trip_ctrl_q}, wdata_q, wmask));
        `OFS_FAULT_INPUT_DETECT: detect_cfg_q <=
          `FD_W'(merge({26'h0000000, detect_cfg_q}, wdata_q, wmask));
        `OFS_CAPTURE_TIMER_CFG: cap_tcfg_q <=
          `CT_W'(merge({27'h0000000, cap_tcfg_q}, wdata_q, wmask));
        `OFS_CAPTURE_TIMER_PHASE: phase_q <= merge(phase_q, wdata_q, wmask);
        default: ;
      endcase
    end
  end

  // Two-flop synchronisers for every pin input.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      fault_s1_q <= 3'h0;
      fault_s2_q <= 3'h0;
      cap_s1_q <= 2'h0;
      cap_s2_q <= 2'h0;
      esync_s1_q <= 3'h0;
      esync_s2_q <= 3'h0;
      esync_prev_q <= 3'h0;
    end else begin
      fault_s1_q <= fault_pin_in;
      fault_s2_q <= fault_s1_q;
      cap_s1_q <= capture_input_in;
      cap_s2_q <= cap_s1_q;
      esync_s1_q <= ext_sync_in;
      esync_s2_q <= esync_s1_q;
      esync_prev_q <= esync_s2_q;
    end
  end

  // Fault events are levels qualified by polarity and generation enable.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      fault_active_q <= 3'h0;
    end else begin
      fault_active_q <= detect_cfg_q[`FD_GEN_EN +: 3] &
        ~(fault_s2_q ^ detect_cfg_q[`FD_POLE +: 3]);
    end
  end

  // Trip state: a new trigger in the clearing cycle wins.
  logic ost_trig, cbc_trig, zero_evt, period_evt, refresh_evt;
  assign ost_trig = |(fault_active_q & trip_action_q[`TA_F_OST +: 3]) ||
    (trip_action_q[`TA_SW_OST] && force_ost_evt);
  assign cbc_trig = |(fault_active_q & trip_action_q[`TA_F_CBC +: 3]) ||
    (trip_action_q[`TA_SW_CBC] && force_cbc_evt);
  assign zero_evt = timer_count_in == 16'h0000;
  assign period_evt = timer_count_in == timer_period_in;
  assign refresh_evt = (trip_ctrl_q[`TC_REFRESH] && zero_evt) ||
    (trip_ctrl_q[`TC_REFRESH + 1] && period_evt);

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ost_q <= 1'b0;
      cbc_q <= 1'b0;
    end else begin
      ost_q <= ost_trig || (ost_q && !clear_ost_evt);
      cbc_q <= cbc_trig || (cbc_q && !refresh_evt);
    end
  end

  function automatic logic apply(input logic [1:0] code, input logic gen);
    unique case (pwm_fault_pkg::trip_action_e'(code))
      pwm_fault_pkg::ACT_KEEP: apply = gen;
      pwm_fault_pkg::ACT_LOW: apply = 1'b0;
      pwm_fault_pkg::ACT_HIGH: apply = 1'b1;
      pwm_fault_pkg::ACT_TOGGLE: apply = ~gen;
    endcase
  endfunction

  // One-shot takes priority over cycle trip when both are active.
  logic [1:0] act_a, act_b;
  always_comb begin
    act_a = 2'h0;
    act_b = 2'h0;
    if (ost_q) begin
      act_a = timer_dir_down_in ? trip_action_q[`TA_A_OST_D +: 2] :
                                  trip_action_q[`TA_A_OST_U +: 2];
      act_b = timer_dir_down_in ? trip_action_q[`TA_B_OST_D +: 2] :
                                  trip_action_q[`TA_B_OST_U +: 2];
    end else if (cbc_q) begin
      act_a = timer_dir_down_in ? trip_action_q[`TA_A_CBC_D +: 2] :
                                  trip_action_q[`TA_A_CBC_U +: 2];
      act_b = timer_dir_down_in ? trip_action_q[`TA_B_CBC_D +: 2] :
                                  trip_action_q[`TA_B_CBC_U +: 2];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else begin
      out_a_q <= apply(act_a, gen_a_in);
      out_b_q <= apply(act_b, gen_b_in);
    end
  end

  // Capture timer with phase load on software or selected hardware sync.
  logic sw_sync_evt, hw_sync, sync_evt;
  assign sw_sync_evt = wr_fire && waddr_q == `OFS_CAPTURE_TIMER_CFG && wstrb_q[0] &&
    wdata_q[`CT_SW_SYNC];
  always_comb begin
    unique case (pwm_fault_pkg::sync_sel_t'(cap_tcfg_q[`CT_SYNC_SEL +: 3]))
      3'h1: hw_sync = timer_sync_in[0];
      3'h2: hw_sync = timer_sync_in[1];
      3'h3: hw_sync = timer_sync_in[2];
      3'h4: hw_sync = esync_s2_q[0] && !esync_prev_q[0];
      3'h5: hw_sync = esync_s2_q[1] && !esync_prev_q[1];
      3'h6: hw_sync = esync_s2_q[2] && !esync_prev_q[2];
      default: hw_sync = 1'b0;
    endcase
  end
  assign sync_evt = sw_sync_evt || (cap_tcfg_q[`CT_SYNC_EN] && hw_sync);

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cap_timer_q <= 32'h00000000;
    end else if (sync_evt) begin
      cap_timer_q <= phase_q;
    end else if (cap_tcfg_q[`CT_RUN]) begin
      cap_timer_q <= cap_timer_q + 32'h00000001;
    end
  end

  // Capture channels.
  wire [`CC_W-1:0] chan_cfg_w [0:1];
  wire [31:0] chan_val_w [0:1];
  wire [1:0] chan_edge_w;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [`CC_W-1:0] cfg_q;
    logic [7:0] pcnt_q;
    logic in_q, ps_q, edge_q, cin, en, rise_pass, fall_pass, sw_evt, cfg_wr;
    logic [31:0] val_q;
    logic [`ADDR_W-1:0] ofs;
    assign ofs = (c == 0) ? `OFS_CAPTURE_CHAN0_CFG : `OFS_CAPTURE_CHAN1_CFG;
    assign cfg_wr = wr_fire && waddr_q == ofs;
    assign cin = cap_s2_q[c] ^ cfg_q[`CC_INVERT];
    assign en = cfg_q[`CC_EN];
    assign rise_pass = en && cin && !in_q &&
      pcnt_q == cfg_q[`CC_PRESCALE +: 8];
    assign fall_pass = en && !cin && in_q && ps_q;
    assign sw_evt = cfg_wr && wstrb_q[1] && wdata_q[`CC_SW];

    always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
        cfg_q <= `CC_RESET;
      end else if (cfg_wr) begin
        cfg_q <= `CC_W'(merge({20'h00000, cfg_q}, wdata_q, wmask));
      end
    end

    // The prescaled signal rises on each passed rising edge and falls with the input.
    always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
        in_q <= 1'b0;
        pcnt_q <= 8'h00;
        ps_q <= 1'b0;
      end else begin
        in_q <= cin;
        if (!en) begin
          pcnt_q <= 8'h00;
          ps_q <= 1'b0;
        end else if (cin && !in_q) begin
          pcnt_q <= rise_pass ? 8'h00 : pcnt_q + 8'h01;
          ps_q <= rise_pass ? 1'b1 : ps_q;
        end else if (!cin && in_q) begin
          ps_q <= 1'b0;
        end
      end
    end

    always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
        val_q <= 32'h00000000;
        edge_q <= 1'b0;
      end else if (en) begin
        if (cfg_q[`CC_MODE] && fall_pass) begin
          val_q <= cap_timer_q;
          edge_q <= 1'b1;
        end else if (cfg_q[`CC_MODE + 1] && rise_pass) begin
          val_q <= cap_timer_q;
          edge_q <= 1'b0;
        end else if (sw_evt) begin
          val_q <= cap_timer_q;
        end
      end
    end

    assign chan_cfg_w[c] = cfg_q;
    assign chan_val_w[c] = val_q;
    assign chan_edge_w[c] = edge_q;
  end

  // Read side: one read at a time, answered one cycle after the address is taken.
  assign raddr = s_axi_araddr_in;
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    unique case (raddr)
      `OFS_TRIP_ACTION_CFG: rd_mux = {8'h00, trip_action_q};
      `OFS_TRIP_CONTROL: rd_mux = {27'h0000000, trip_ctrl_q};
      `OFS_TRIP_STATUS: begin
        rd_mux[`TS_OST_ON] = ost_q;
        rd_mux[`TS_CBC_ON] = cbc_q;
      end
      `OFS_FAULT_INPUT_DETECT: rd_mux = {23'h000000, fault_active_q, detect_cfg_q};
      `OFS_CAPTURE_TIMER_CFG: rd_mux = {27'h0000000, cap_tcfg_q};
      `OFS_CAPTURE_TIMER_PHASE: rd_mux = phase_q;
      `OFS_CAPTURE_CHAN0_CFG: rd_mux = {20'h00000, chan_cfg_w[0]};
      `OFS_CAPTURE_CHAN1_CFG: rd_mux = {20'h00000, chan_cfg_w[1]};
      `OFS_CAPTURE_CHAN0_VALUE: rd_mux = chan_val_w[0];
      `OFS_CAPTURE_CHAN1_VALUE: rd_mux = chan_val_w[1];
      `OFS_CAPTURE_EDGE_STATUS: rd_mux = {30'h00000000, chan_edge_w};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (s_axi_arvalid_in && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule // pwm_fault_trip_and_capture

/* File: verif/pwm_fault_trip_and_capture_monitor.sv */
// Checker of bus handshakes and reset state of the fault trip and capture block.
`include "pwm_fault_params.svh"
module pwm_fault_trip_and_capture_monitor (
  input wire logic clk_sys_in, // Clock.
  input wire logic reset_in, // Reset.
  input wire logic s_axi_awvalid_in, // Write address valid.
  input wire logic s_axi_awready_out, // Write address ready.
  input wire logic s_axi_wvalid_in, // Write data valid.
  input wire logic s_axi_wready_out, // Write data ready.
  input wire logic [1:0] s_axi_bresp_out, // Write response.
  input wire logic s_axi_bvalid_out, // Write response valid.
  input wire logic s_axi_bready_in, // Write response ready.
  input wire logic s_axi_arvalid_in, // Read address valid.
  input wire logic s_axi_arready_out, // Read address ready.
  input wire logic [31:0] s_axi_rdata_out, // Read data.
  input wire logic [1:0] s_axi_rresp_out, // Read response.
  input wire logic s_axi_rvalid_out, // Read data valid.
  input wire logic s_axi_rready_in, // Read data ready.
  input wire logic output_a_out, // Tripped output_a.
  input wire logic output_b_out // Tripped output_b.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence s_both_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_resp_waiting;
    s_axi_bvalid_out && !s_axi_bready_in;
  endsequence
  chk_write_answer: assert property (s_both_taken |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response missing after both channels taken");
  chk_bresp_hold: assert property (s_resp_waiting |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped or changed before bready");
  chk_bresp_code: assert property (s_axi_bvalid_out |->
    (s_axi_bresp_out == `RESP_OKAY || s_axi_bresp_out == `RESP_SLVERR))
    else $error("write response code illegal");
  chk_write_block: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write channel ready while response pending");
  chk_bresp_release: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response not released");
  chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data not returned one cycle after address");
  chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
    else $error("read data dropped or changed before rready");
  chk_read_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address ready while data pending");
  chk_quiet_reset: assert property (disable iff (1'b0) reset_in |=>
    !s_axi_bvalid_out && !s_axi_rvalid_out && !output_a_out && !output_b_out)
    else $error("outputs not cleared by reset");
endmodule // pwm_fault_trip_and_capture_monitor

bind pwm_fault_trip_and_capture pwm_fault_trip_and_capture_monitor mon (.*);

/* File: verif/pin_routing_model.sv */
// Model of the pin routing that delivers fault, capture and external sync levels.
module pin_routing_model (
  input wire logic clk_sys_in, // System clock.
  output logic [2:0] fault_pin_out, // Fault levels.
  output logic [1:0] capture_pin_out, // Capture levels.
  output logic [2:0] ext_sync_out // External sync levels.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fault_pin_out = 3'h7;
    capture_pin_out = 2'h0;
    ext_sync_out = 3'h0;
  end
  // Fault pins are plain levels held until changed.
  task automatic set_fault(input int idx, input logic lvl);
    @(posedge clk_sys_in);
    fault_pin_out[idx] <= lvl;
  endtask
  // Pulses last four cycles so the synchronisers see each edge once.
  task automatic pulse(input logic to_sync, input int idx);
    @(posedge clk_sys_in);
    if (to_sync) ext_sync_out[idx] <= 1'b1;
    else capture_pin_out[idx] <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    if (to_sync) ext_sync_out[idx] <= 1'b0;
    else capture_pin_out[idx] <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask
endmodule // pin_routing_model

/* File: verif/tb_pwm_fault_trip_and_capture.sv */
// Self-checking testbench of the fault trip and capture block.
`include "pwm_fault_params.svh"
module tb_pwm_fault_trip_and_capture;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [11:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic [31:0] s_axi_wdata_in = '0;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [15:0] timer_count_in = 16'h0005, timer_period_in = 16'h0064;
  logic timer_dir_down_in = 1'b0, gen_a_in = 1'b1, gen_b_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, output_a_out, output_b_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, capture_input_in, rr, br;
  logic [31:0] s_axi_rdata_out, rv, v1, ctl = '0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic [2:0] fault_pin_in, ext_sync_in, timer_sync_in = 3'h0;
  int miscompares = 0, checks_done = 0, cycles = 0;

  pwm_fault_trip_and_capture dut (.clk_sys_in, .reset_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .fault_pin_in, .capture_input_in, .ext_sync_in, .timer_sync_in,
    .timer_count_in, .timer_period_in, .timer_dir_down_in, .gen_a_in, .gen_b_in,
    .output_a_out, .output_b_out);
  pin_routing_model pins (.clk_sys_in, .fault_pin_out(fault_pin_in),
    .capture_pin_out(capture_input_in), .ext_sync_out(ext_sync_in));

  initial forever #5 clk_sys_in = ~clk_sys_in;

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    br = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out);
    rv = s_axi_rdata_out;
    rr = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic pins_chk(input logic [1:0] e);
    chk({30'h0, output_a_out, output_b_out}, {30'h0, e});
  endtask
  task automatic toggle_ctl(input logic [31:0] m);
    ctl = ctl ^ m;
    wr(12'h0DC, ctl);
    tick(4);
  endtask

  task automatic reg_test();
    logic [11:0] regs[5] = '{12'h0D8, 12'h0E4, 12'h0E8, 12'h0EC, 12'h0F0};
    foreach (regs[i]) rd_chk(regs[i], 32'h0);
    wr(12'h010, 32'h1);
    rd_chk(12'h010, 32'h0);
    chk({28'h0, br, rr}, {28'h0, `RESP_SLVERR, `RESP_SLVERR});
    wr(12'h0EC, 32'hA5A55A5A);
    rd_chk(12'h0EC, 32'hA5A55A5A);
    s_axi_wstrb_in <= 4'h1;
    wr(12'h0EC, 32'hFFFFFFFF);
    s_axi_wstrb_in <= 4'hF;
    rd_chk(12'h0EC, 32'hA5A55AFF);
    wr(12'h0E0, 32'h3);
    rd_chk(12'h0E0, 32'h0);
  endtask

  task automatic fault_test();
    wr(12'h0D8, 32'h00804000);
    pins.set_fault(0, 1'b0);
    tick(8);
    rd_chk(12'h0E4, 32'h0);
    wr(12'h0E4, 32'h1);
    tick(8);
    rd_chk(12'h0E4, 32'h41);
    rd_chk(12'h0E0, 32'h0);
    wr(12'h0D8, 32'h00804020);
    tick(4);
    rd_chk(12'h0E0, 32'h2);
    pins_chk(2'b01);
    pins.set_fault(0, 1'b1);
    tick(8);
    rd_chk(12'h0E4, 32'h1);
    rd_chk(12'h0E0, 32'h2);
    toggle_ctl(32'h1);
    rd_chk(12'h0E0, 32'h0);
    pins_chk(2'b10);
    wr(12'h0E4, 32'h9);
    tick(8);
    rd_chk(12'h0E4, 32'h49);
    rd_chk(12'h0E0, 32'h2);
    wr(12'h0E4, 32'h0);
    toggle_ctl(32'h1);
  endtask

  task automatic sw_trip_test();
    logic [1:0] e[4] = '{2'b10, 2'b00, 2'b11, 2'b01};
    timer_dir_down_in <= 1'b1;
    wr(12'h0D8, 32'h0);
    toggle_ctl(32'h10);
    rd_chk(12'h0E0, 32'h0);
    for (int act = 0; act < 4; act++) begin
      wr(12'h0D8, 32'h10 | (act << 12) | (act << 20));
      toggle_ctl(32'h10);
      rd_chk(12'h0E0, 32'h2);
      pins_chk(e[act]);
      toggle_ctl(32'h1);
    end
  endtask

  task automatic cycle_test();
    timer_dir_down_in <= 1'b0;
    wr(12'h0D8, 32'h00040C01);
    ctl = ctl | 32'h2;
    toggle_ctl(32'h8);
    rd_chk(12'h0E0, 32'h1);
    pins_chk(2'b00);
    timer_count_in <= 16'h0000;
    tick(4);
    rd_chk(12'h0E0, 32'h0);
    pins_chk(2'b10);
    timer_count_in <= 16'h0005;
    ctl = (ctl & ~32'h6) | 32'h4;
    toggle_ctl(32'h8);
    timer_count_in <= 16'h0000;
    tick(4);
    rd_chk(12'h0E0, 32'h1);
    timer_count_in <= 16'h0064;
    tick(4);
    rd_chk(12'h0E0, 32'h0);
  endtask

  task automatic capture_test();
    wr(12'h0EC, 32'h100);
    wr(12'h0E8, 32'h20);
    rd_chk(12'h0E8, 32'h0);
    wr(12'h0F0, 32'h1000);
    rd_chk(12'h0FC, 32'h0);
    wr(12'h0F0, 32'h1);
    wr(12'h0F0, 32'h1001);
    rd_chk(12'h0FC, 32'h100);
    wr(12'h0EC, 32'h200);
    wr(12'h0E8, 32'h20);
    wr(12'h0F4, 32'h803);
    pins.pulse(1'b0, 1);
    pins.pulse(1'b0, 1);
    rd_chk(12'h100, 32'h200);
    wr(12'h0EC, 32'h300);
    wr(12'h0E8, 32'h20);
    wr(12'h0F0, 32'hD);
    pins.pulse(1'b0, 0);
    rd_chk(12'h0FC, 32'h100);
    pins.pulse(1'b0, 0);
    rd_chk(12'h0FC, 32'h300);
    rd_chk(12'h108, 32'h2);
    wr(12'h0E8, 32'h1);
    wr(12'h0F0, 32'h100D);
    rd(12'h0FC);
    v1 = rv;
    wr(12'h0F0, 32'h100D);
    rd(12'h0FC);
    chk({31'h0, rv > v1}, 32'h1);
  endtask

  task automatic sync_test();
    wr(12'h0EC, 32'h400);
    wr(12'h0E8, 32'h12);
    pins.pulse(1'b1, 0);
    wr(12'h0F0, 32'h100D);
    rd_chk(12'h0FC, 32'h400);
    wr(12'h0EC, 32'h500);
    wr(12'h0E8, 32'h10);
    pins.pulse(1'b1, 0);
    wr(12'h0F0, 32'h100D);
    rd_chk(12'h0FC, 32'h400);
    wr(12'h0E8, 32'h0A);
    timer_sync_in <= 3'h2;
    tick(1);
    timer_sync_in <= 3'h0;
    wr(12'h0F0, 32'h100D);
    rd_chk(12'h0FC, 32'h500);
  endtask

  initial begin
    tick(4);
    reset_in <= 1'b0;
    reg_test();
    fault_test();
    sw_trip_test();
    cycle_test();
    capture_test();
    sync_test();
    test_done();
  end
endmodule // tb_pwm_fault_trip_and_capture
